// file: src/pmw_top.sv
// Port-mapped watchdog: control byte, kick port and alarm
//
// Operation
// - Control bit 0 turns timeout supervision off at 0 and on at 1.
// - Control bit 1 picks standard timeouts at 0 and macro timeouts at 1.
// - Control bits 5..3 pick 94..960 ms in standard mode or 2..64 s in macro mode.
// - Control bit 6 drives the red alarm lamp directly.
// - Control bit 7 reads 1 once the watchdog has expired and 0 otherwise.
// - Writing 1 to control bit 7 clears the error flag and the alarm display unless the watchdog expires in the same cycle.
// - The control byte is read and written at port 062h.
// - Any read of port 066h restarts the timeout.
// - Data read from port 066h has no meaning.
`timescale 1ns/1ps
module pmw_top
  import pmw_pkg::*;
#(
  parameter longint STD_DIV = 64'd1,
  parameter longint MAC_DIV = 64'd1
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Port access
  input wire pmw_io_req_t io_req_in,
  output logic [7:0] io_rdata_out,
  // Indicators
  output logic supervisor_alarm_lamp_out,
  output logic alarm_out
);
  logic supervision_on_bit_q;
  logic mode_q;
  logic sel_q;
  logic [2:0] scaler_q;
  logic lamp_q;
  logic err_q;
  logic ctrl_wr;
  logic ctrl_rd;
  logic kick_rd;
  logic expire;
  pmw_cfg_t cfg;
  logic [PMW_CNT_W-1:0] quiet_q;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic logic port_hit(input pmw_io_req_t req, input logic [15:0] port, input logic is_read);
    logic strobe;
    strobe = is_read ? req.rd : req.wr;
    return strobe && req.addr == port;
  endfunction

  function automatic logic [7:0] ctrl_byte(input logic err, input logic lamp, input logic [2:0] scaler,
    input logic sel, input logic mode, input logic en);
    logic [7:0] b;
    b = 8'h00;
    b[PMW_BIT_ERR] = err;
    b[PMW_BIT_LAMP] = lamp;
    b[PMW_SCL_LO +: 3] = scaler;
    b[PMW_BIT_SEL] = sel;
    b[PMW_BIT_MODE] = mode;
    b[PMW_BIT_EN] = en;
    return b;
  endfunction

  function automatic logic [PMW_CNT_W-1:0] longest_wait();
    longint t_std;
    longint t_mac;
    t_std = PMW_STD_MS[7] * PMW_CLK_HZ / (64'd1000 * STD_DIV);
    t_mac = PMW_MAC_S[7] * PMW_CLK_HZ / MAC_DIV;
    if (t_std > t_mac)
    begin
      t_mac = t_std;
    end
    if (t_mac < 64'd1)
    begin
      t_mac = 64'd1;
    end
    return PMW_CNT_W'(t_mac);
  endfunction

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign ctrl_wr = port_hit(io_req_in, PMW_CTRL_ADDR, 1'b0);
  assign ctrl_rd = port_hit(io_req_in, PMW_CTRL_ADDR, 1'b1);
  assign kick_rd = port_hit(io_req_in, PMW_KICK_ADDR, 1'b1);

  // ---------------------------------------------------------------
  // Control byte
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      supervision_on_bit_q <= 1'b0;
      mode_q <= 1'b0;
      sel_q <= PMW_SEL_RESET;
      scaler_q <= PMW_SCL_RESET;
      lamp_q <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      supervision_on_bit_q <= io_req_in.wdata[PMW_BIT_EN];
      mode_q <= io_req_in.wdata[PMW_BIT_MODE];
      sel_q <= io_req_in.wdata[PMW_BIT_SEL];
      scaler_q <= io_req_in.wdata[PMW_SCL_LO +: 3];
      lamp_q <= io_req_in.wdata[PMW_BIT_LAMP];
    end
  end

  // ---------------------------------------------------------------
  // Error flag, expiry wins over a clear in the same cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      err_q <= 1'b0;
    end
    else if (expire)
    begin
      err_q <= 1'b1;
    end
    else if (ctrl_wr && io_req_in.wdata[PMW_BIT_ERR])
    begin
      err_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Timer
  // ---------------------------------------------------------------
  assign cfg = '{en: supervision_on_bit_q, mode: mode_q, scaler: scaler_q};

  pmw_timer #(
    .CNT_W(PMW_CNT_W),
    .STD_DIV(STD_DIV),
    .MAC_DIV(MAC_DIV)
  ) u_timer (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .cfg_in(cfg),
    .kick_in(kick_rd),
    .expire_out(expire)
  );

  // ---------------------------------------------------------------
  // Read data and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      io_rdata_out <= 8'h00;
    end
    else if (ctrl_rd)
    begin
      io_rdata_out <= ctrl_byte(err_q, lamp_q, scaler_q, sel_q, mode_q, supervision_on_bit_q);
    end
    else if (kick_rd)
    begin
      io_rdata_out <= PMW_KICK_DATA;
    end
  end

  assign supervisor_alarm_lamp_out = lamp_q;
  assign alarm_out = err_q;

  // ---------------------------------------------------------------
  // Check helper: cycles spent supervising without a kick
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      quiet_q <= '0;
    end
    else if (!supervision_on_bit_q || kick_rd || expire)
    begin
      quiet_q <= '0;
    end
    else
    begin
      quiet_q <= quiet_q + PMW_CNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Checks: error flag and alarm
  // ---------------------------------------------------------------
  chk_expire_sets_err: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    expire
    |=> err_q && alarm_out)
    else $error("expiry did not raise alarm");
  chk_clear_drops_err: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ctrl_wr && io_req_in.wdata[PMW_BIT_ERR] && !expire
    |=> !err_q)
    else $error("clear ignored");
  chk_err_sticky: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    err_q && !ctrl_wr
    |=> err_q)
    else $error("error flag dropped alone");
  chk_no_err_disabled: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !supervision_on_bit_q && !err_q && !expire
    |=> !err_q)
    else $error("error while disabled");
  chk_alarm_rise: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    $rose(alarm_out)
    |-> $past(expire))
    else $error("alarm rose without expiry");
  chk_alarm_fall: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    $fell(alarm_out)
    |-> $past(ctrl_wr && io_req_in.wdata[PMW_BIT_ERR]))
    else $error("alarm fell without clear");
  chk_expire_needs_on: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    expire
    |-> $past(supervision_on_bit_q) && !$past(kick_rd))
    else $error("expiry without supervision");
  chk_quiet_bounded: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    supervision_on_bit_q
    |-> quiet_q <= longest_wait())
    else $error("timeout overran longest wait");
  chk_kick_keeps_alarm: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    kick_rd && !expire && !alarm_out
    |=> !alarm_out)
    else $error("alarm after kick");
  chk_kick_no_clear: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    alarm_out && kick_rd
    |=> alarm_out)
    else $error("kick cleared alarm");

  // ---------------------------------------------------------------
  // Checks: control byte
  // ---------------------------------------------------------------
  chk_lamp_follows: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ctrl_wr
    |=> supervisor_alarm_lamp_out == $past(io_req_in.wdata[PMW_BIT_LAMP]))
    else $error("lamp mismatch");
  chk_lamp_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !ctrl_wr
    |=> $stable(supervisor_alarm_lamp_out))
    else $error("lamp changed alone");
  chk_lamp_no_alarm: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    expire && !ctrl_wr
    |=> $stable(supervisor_alarm_lamp_out))
    else $error("lamp moved on expiry");
  chk_enable_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ctrl_wr
    |=> supervision_on_bit_q == $past(io_req_in.wdata[PMW_BIT_EN]))
    else $error("enable mismatch");
  chk_mode_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ctrl_wr
    |=> mode_q == $past(io_req_in.wdata[PMW_BIT_MODE]) && scaler_q == $past(io_req_in.wdata[PMW_SCL_LO +: 3]))
    else $error("mode or scaler mismatch");
  chk_sel_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ctrl_wr
    |=> sel_q == $past(io_req_in.wdata[PMW_BIT_SEL]))
    else $error("select bit mismatch");
  chk_cfg_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !ctrl_wr
    |=> $stable(cfg) && $stable(sel_q))
    else $error("control byte changed alone");
  chk_kick_keeps_cfg: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    kick_rd && !ctrl_wr
    |=> $stable(cfg))
    else $error("kick changed control byte");

  // ---------------------------------------------------------------
  // Checks: read data
  // ---------------------------------------------------------------
  chk_ctrl_readback: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ctrl_rd
    |=> io_rdata_out[PMW_SCL_LO +: 3] == $past(scaler_q) && io_rdata_out[PMW_BIT_EN] == $past(supervision_on_bit_q))
    else $error("readback mismatch");
  chk_readback_low: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ctrl_rd
    |=> io_rdata_out[PMW_BIT_LAMP] == $past(lamp_q) && io_rdata_out[PMW_BIT_SEL] == $past(sel_q) && io_rdata_out[PMW_BIT_MODE] == $past(mode_q))
    else $error("readback field mismatch");
  chk_err_readback: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ctrl_rd
    |=> io_rdata_out[PMW_BIT_ERR] == $past(alarm_out))
    else $error("error bit readback mismatch");
  chk_kick_data: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    kick_rd
    |=> io_rdata_out == PMW_KICK_DATA)
    else $error("kick read data mismatch");
  chk_rdata_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !ctrl_rd && !kick_rd
    |=> $stable(io_rdata_out))
    else $error("read data changed alone");
  chk_unmapped_rd: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    io_req_in.rd && !ctrl_rd && !kick_rd
    |=> $stable(io_rdata_out))
    else $error("unmapped read changed data");
  chk_write_no_rdata: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ctrl_wr && !io_req_in.rd
    |=> $stable(io_rdata_out))
    else $error("write changed read data");
endmodule

// file: src/pmw_pkg.sv
// Package of constants and types for the port-mapped watchdog
package pmw_pkg;
  // ---------------------------------------------------------------
  // Port map
  // ---------------------------------------------------------------
  localparam logic [15:0] PMW_CTRL_ADDR = 16'h0062;
  localparam logic [15:0] PMW_KICK_ADDR = 16'h0066;
  // ---------------------------------------------------------------
  // Control byte fields
  // ---------------------------------------------------------------
  localparam int PMW_BIT_EN = 0;
  localparam int PMW_BIT_MODE = 1;
  localparam int PMW_BIT_SEL = 2;
  localparam int PMW_SCL_LO = 3;
  localparam int PMW_BIT_LAMP = 6;
  localparam int PMW_BIT_ERR = 7;
  localparam logic [2:0] PMW_SCL_RESET = 3'h0;
  localparam logic PMW_SEL_RESET = 1'h1;
  localparam logic [7:0] PMW_KICK_DATA = 8'hFF;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint PMW_CLK_HZ = 64'd10000000;
  localparam longint PMW_STD_MS [8] = '{94, 210, 340, 460, 590, 710, 840, 960};
  localparam longint PMW_MAC_S [8] = '{2, 4, 6, 8, 16, 32, 48, 64};
  localparam int PMW_CNT_W = 30;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pmw_io_req_t;
  typedef struct packed {
    logic en;
    logic mode;
    logic [2:0] scaler;
  } pmw_cfg_t;
endpackage

// file: src/pmw_timer.sv
// Timeout counter of the port-mapped watchdog
`timescale 1ns/1ps
module pmw_timer
  import pmw_pkg::*;
#(
  parameter int CNT_W = PMW_CNT_W,
  parameter longint STD_DIV = 64'd1,
  parameter longint MAC_DIV = 64'd1
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Control
  input wire pmw_cfg_t cfg_in,
  input wire logic kick_in,
  // Expiry
  output logic expire_out
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;

  // ---------------------------------------------------------------
  // Limit lookup
  // ---------------------------------------------------------------
  function automatic logic [CNT_W-1:0] limit_of(input logic mode, input logic [2:0] code);
    longint t;
    if (mode)
    begin
      t = PMW_MAC_S[code] * PMW_CLK_HZ / MAC_DIV;
    end
    else
    begin
      t = PMW_STD_MS[code] * PMW_CLK_HZ / (64'd1000 * STD_DIV);
    end
    if (t < 64'd1)
    begin
      t = 64'd1;
    end
    return CNT_W'(t);
  endfunction

  assign limit = limit_of(cfg_in.mode, cfg_in.scaler);

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cnt_q <= '0;
      expire_out <= 1'b0;
    end
    else
    begin
      expire_out <= 1'b0;
      if (!cfg_in.en || kick_in)
      begin
        cnt_q <= '0;
      end
      else if (cnt_q >= limit - CNT_W'(1))
      begin
        cnt_q <= '0;
        expire_out <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  chk_idle_no_expire: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !cfg_in.en |=> !expire_out) else $error("expiry while disabled");
  chk_kick_restarts: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    kick_in |=> cnt_q == '0 && !expire_out) else $error("kick did not restart");
endmodule

// file: test/pmw_host.sv
// Host software model issuing port accesses to the watchdog
`timescale 1ns/1ps
module pmw_host
  import pmw_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Port access
  input wire logic [7:0] io_rdata_in,
  output pmw_io_req_t io_req_out
);
  initial io_req_out = '0;
  // One access; afterwards both strobes drop to 0 and address and data carry inverted values
  task automatic acc(input logic r, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    io_req_out <= '{r, !r, a, d};
    @(posedge clk_in);
    io_req_out <= '{1'b0, 1'b0, ~a, ~d};
    #1 q = io_rdata_in;
  endtask
  // Control writes keep the select bit set
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b0, a, (a == PMW_CTRL_ADDR) ? (d | 8'h04) : d, q);
  endtask
  // Kick read, data discarded
  task automatic kick();
    logic [7:0] q;
    acc(1'b1, PMW_KICK_ADDR, 8'h00, q);
  endtask
endmodule

// file: test/tb_top.sv
// Self-checking testbench of the port-mapped watchdog
`timescale 1ns/1ps
module tb_top;
  import pmw_pkg::*;
  localparam longint SD = 64'd10000;
  localparam longint MD = 64'd1000000;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] io_rdata_out;
  logic lamp;
  logic alarm;
  pmw_io_req_t io_req;
  int error_cnt = 0;
  int cmp_count = 0;
  int ctrl_m;
  int n;
  logic [7:0] q;
  always #50 clk_in = ~clk_in;
  pmw_top #(.STD_DIV(SD), .MAC_DIV(MD)) i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .io_req_in(io_req),
    .io_rdata_out(io_rdata_out), .supervisor_alarm_lamp_out(lamp), .alarm_out(alarm));
  pmw_host i_host (.clk_in(clk_in), .io_rdata_in(io_rdata_out), .io_req_out(io_req));
  // -------------------------------------------------------------
  // Checking
  // -------------------------------------------------------------
  task automatic end_of_test();
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  // Model of the control byte
  task automatic wc(input logic [7:0] d);
    i_host.wr(PMW_CTRL_ADDR, d);
    ctrl_m = (d | 8'h04) & 8'h7F;
  endtask
  task automatic rdc();
    i_host.acc(1'b1, PMW_CTRL_ADDR, 8'h00, q);
    chk8(q, 8'(ctrl_m));
    chk1(lamp, ctrl_m[6]);
  endtask
  function automatic int nt(input int m, input int c);
    return m ? int'(PMW_MAC_S[c] * PMW_CLK_HZ / MD) : int'(PMW_STD_MS[c] * PMW_CLK_HZ / 1000 / SD);
  endfunction
  // -------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------
  initial
  begin
    void'($urandom(54));
    ctrl_m = 8'h04;
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    chk1(alarm, 1'b0);
    rdc();
    wc(8'h40);
    repeat (1100) @(posedge clk_in);
    chk1(alarm, 1'b0);
    rdc();
    i_host.wr(16'(16'h0063 + ($urandom % 2)), 8'($urandom));
    i_host.acc(1'b1, 16'h0060, 8'h00, q);
    chk8(q, 8'(ctrl_m));
    rdc();
    wc(8'h01);
    repeat (5)
    begin
      repeat (60) @(posedge clk_in);
      i_host.kick();
    end
    chk1(alarm, 1'b0);
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 8; c++)
      begin
        wc(8'(8'h81 | (m << 1) | (c << 3) | (($urandom % 2) << 6)));
        chk1(alarm, 1'b0);
        i_host.kick();
        n = nt(m, c);
        repeat (n - 4) @(posedge clk_in);
        #1;
        chk1(alarm, 1'b0);
        repeat (8) @(posedge clk_in);
        #1;
        chk1(alarm, 1'b1);
        ctrl_m = ctrl_m | 8'h80;
        rdc();
      end
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    #1;
    chk1(alarm, 1'b0);
    ctrl_m = 8'h04;
    rdc();
    end_of_test();
  end
  // Watchdog against a hang
  initial
  begin
    #2000000;
    error_cnt++;
    end_of_test();
  end
endmodule
